// *** signal_combiner.sv ***
`timescale 1ns/1ps
// operator selection and output polarity for the combined signal
module signal_combiner (
    input  wire logic i_horiz,     // horizontal component
    input  wire logic i_vert,      // vertical component
    input  wire logic i_sel_and,   // and selection
    input  wire logic i_sel_or,    // or selection
    input  wire logic i_sel_xor,   // xor selection
    input  wire logic i_polarity,  // 1 = active low
    output logic      o_level      // pin level
);
    logic both_on;    // and result
    logic either_on;  // or result
    logic one_on;     // xor result
    logic active;     // selected result

    assign both_on   = i_horiz & i_vert;
    assign either_on = i_horiz | i_vert;
    assign one_on    = i_horiz ^ i_vert;

    // and wins over or, or over xor
    assign active = i_sel_and ? both_on :
                    i_sel_or  ? either_on :
                    i_sel_xor ? one_on : 1'b0;

    // polarity 1 inverts the active level
    assign o_level = active ^ i_polarity;
endmodule : signal_combiner

// *** tb_top.sv ***
`timescale 1ns/1ps
// register bus and video window bench
module tb_top;
    import utsc_pkg::*;
    localparam addr_t a_hs = 10'h170; // horizontal start
    localparam addr_t a_op = 10'h180; // combine and polarity
    localparam addr_t a_no = 10'h3F0; // unmapped
    logic  i_clock, i_rst_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_bready;
    logic  i_s_axi_arvalid, i_s_axi_rready, i_interlaced, o_s_axi_awready;
    logic  o_s_axi_wready, o_s_axi_bvalid, o_s_axi_arready, o_s_axi_rvalid;
    logic  o_user_b_horiz_component, o_user_b_vert_component, o_user_b_combined_output;
    addr_t i_s_axi_awaddr, i_s_axi_araddr;
    data_t i_s_axi_wdata, o_s_axi_rdata, rd;
    strb_t i_s_axi_wstrb;
    resp_t o_s_axi_bresp, o_s_axi_rresp, rsp;
    pix_t  i_pixel_count;
    line_t i_line_count, i_lines_per_field;
    int    error_cnt, checks_done;
    logic [3:0] op;                                   // combine value in use
    logic [3:0] ops [6] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h7, 4'h3};
    pix_t  bp [4] = '{16'h0009, 16'h000A, 16'h0013, 16'h0014}; // edge pixels
    line_t bl [4] = '{15'h0004, 15'h0005, 15'h0007, 15'h0008}; // edge lines
    line_t il [4] = '{15'h000F, 15'h0012, 15'h000E, 15'h0005}; // interlaced lines
    logic  be [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    logic  ie [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    user_timing_signal_two_combiner DUT (
        .i_clock, .i_rst_n, .i_s_axi_awaddr, .i_s_axi_awvalid, .o_s_axi_awready,
        .i_s_axi_wdata, .i_s_axi_wstrb, .i_s_axi_wvalid, .o_s_axi_wready, .o_s_axi_bresp,
        .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_araddr, .i_s_axi_arvalid,
        .o_s_axi_arready, .o_s_axi_rdata, .o_s_axi_rresp, .o_s_axi_rvalid, .i_s_axi_rready,
        .i_pixel_count, .i_line_count, .i_interlaced, .i_lines_per_field,
        .o_user_b_horiz_component, .o_user_b_vert_component, .o_user_b_combined_output);
    // 40 MHz clock
    initial begin
        i_clock = 1'b0;
        forever #12.5 i_clock = ~i_clock;
    end
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            error_cnt++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // write with address and data offered together
    task automatic bus_wr(input addr_t a, input data_t d, output resp_t r);
        logic aw_done, w_done;
        aw_done = 1'b0;
        w_done = 1'b0;
        i_s_axi_awaddr <= a;
        i_s_axi_wdata <= d;
        i_s_axi_awvalid <= 1'b1;
        i_s_axi_wvalid <= 1'b1;
        while (!(aw_done && w_done)) begin
            @(posedge i_clock);
            if (i_s_axi_awvalid && o_s_axi_awready) begin
                aw_done = 1'b1;
                i_s_axi_awvalid <= 1'b0;
            end
            if (i_s_axi_wvalid && o_s_axi_wready) begin
                w_done = 1'b1;
                i_s_axi_wvalid <= 1'b0;
            end
        end
        do @(posedge i_clock); while (!o_s_axi_bvalid);
        r = o_s_axi_bresp;
    endtask : bus_wr
    task automatic bus_rd(input addr_t a, output data_t d, output resp_t r);
        i_s_axi_araddr <= a;
        i_s_axi_arvalid <= 1'b1;
        do @(posedge i_clock); while (!o_s_axi_arready);
        i_s_axi_arvalid <= 1'b0;
        do @(posedge i_clock); while (!o_s_axi_rvalid);
        d = o_s_axi_rdata;
        r = o_s_axi_rresp;
    endtask : bus_rd
    // set counters and let both pipeline stages settle
    task automatic vid(input pix_t p, input line_t l);
        i_pixel_count <= p;
        i_line_count <= l;
        repeat (3) @(posedge i_clock);
    endtask : vid
    function automatic logic exp_out(input logic [3:0] o, input logic h, input logic v);
        logic a;
        a = o[2] ? (h & v) : o[1] ? (h | v) : o[0] ? (h ^ v) : 1'b0;
        return a ^ o[3];
    endfunction : exp_out
    task automatic close_out;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : close_out
    // watchdog
    initial begin
        #500000;
        error_cnt++;
        close_out();
    end
    initial begin
        {i_rst_n, i_s_axi_awvalid, i_s_axi_wvalid, i_s_axi_arvalid, i_interlaced} = '0;
        {i_s_axi_awaddr, i_s_axi_araddr, i_s_axi_wdata} = '0;
        {i_s_axi_bready, i_s_axi_rready, i_s_axi_wstrb} = 6'h3F;
        {i_pixel_count, i_line_count} = '0;
        i_lines_per_field = 15'h000A;
        error_cnt = 0;
        checks_done = 0;
        repeat (12) @(posedge i_clock);
        i_rst_n <= 1'b1;
        @(posedge i_clock);
        chk("pin after reset", 32'h1, o_user_b_combined_output);
        for (int i = 0; i < 5; i++) begin
            bus_rd(addr_t'(a_hs + 4 * i), rd, rsp);
            chk("reset value", (i == 4) ? 32'h8 : 32'h0, rd);
        end
        $display("test reset done");
        bus_rd(a_no, rd, rsp);
        chk("unmapped read resp", 32'h2, rsp);
        bus_wr(a_no, 32'h1, rsp);
        chk("unmapped write resp", 32'h2, rsp);
        bus_wr(10'h178, 32'h7FFF, rsp);
        bus_rd(10'h178, rd, rsp);
        chk("vertical start", 32'h7FFF, rd);
        bus_wr(a_op, 32'h000F, rsp);
        bus_rd(a_op, rd, rsp);
        chk("combine reg", 32'hF, rd);
        $display("test registers done");
        bus_wr(a_hs, 32'h000A, rsp);
        bus_wr(10'h174, 32'h0014, rsp);
        bus_wr(10'h178, 32'h0005, rsp);
        bus_wr(10'h17C, 32'h0008, rsp);
        bus_wr(a_op, 32'h0, rsp);
        for (int i = 0; i < 4; i++) begin
            vid(bp[i], bl[i]);
            chk("horiz", be[i], o_user_b_horiz_component);
            chk("vert", be[i], o_user_b_vert_component);
        end
        $display("test windows done");
        for (int j = 0; j < 12; j++) begin
            op = ops[j % 6] | ((j >= 6) ? 4'h8 : 4'h0);
            bus_wr(a_op, {28'h0, op}, rsp);
            for (int m = 0; m < 4; m++) begin
                vid(m[0] ? 16'h000A : 16'h0014, m[1] ? 15'h0005 : 15'h0008);
                chk("combined", exp_out(op, m[0], m[1]), o_user_b_combined_output);
            end
        end
        bus_rd(10'h1C0, rd, rsp);
        chk("status", 32'h3, rd);
        $display("test operators done");
        i_interlaced <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            vid(16'h000A, il[i]);
            chk("vert interlaced", ie[i], o_user_b_vert_component);
        end
        i_interlaced <= 1'b0;
        vid(16'h000A, 15'h000F);
        chk("vert progressive", 32'h0, o_user_b_vert_component);
        $display("test interlace done");
        close_out();
    end
endmodule : tb_top

// *** user_timing_signal_two_combiner.sv ***
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/1ps
`include "utsc_defs.svh"
// Overview of operation
// - vertical component starts at start line
// - vertical component ends at end line
// - interlaced lines compared as odd-field numbers
// - bit 3 sets combined output polarity
// - polarity resets to 1, active low
// - polarity 0 gives active high output
// - bit 2 selects horizontal and vertical
// - and selection overrides or and xor
// - bit 1 selects horizontal or vertical
// - or selection overrides xor
// - bit 0 selects exactly one active
// - horizontal component starts at start pixel
// - horizontal component ends at end pixel
module user_timing_signal_two_combiner (
    input  wire logic             i_clock,              // video clock, 40 MHz
    input  wire logic             i_rst_n,              // async reset, active low
    input  wire utsc_pkg::addr_t  i_s_axi_awaddr,       // write address
    input  wire logic             i_s_axi_awvalid,      // write address valid
    output logic                  o_s_axi_awready,      // write address ready
    input  wire utsc_pkg::data_t  i_s_axi_wdata,        // write data
    input  wire utsc_pkg::strb_t  i_s_axi_wstrb,        // write byte enables
    input  wire logic             i_s_axi_wvalid,       // write data valid
    output logic                  o_s_axi_wready,       // write data ready
    output utsc_pkg::resp_t       o_s_axi_bresp,        // write response
    output logic                  o_s_axi_bvalid,       // write response valid
    input  wire logic             i_s_axi_bready,       // write response ready
    input  wire utsc_pkg::addr_t  i_s_axi_araddr,       // read address
    input  wire logic             i_s_axi_arvalid,      // read address valid
    output logic                  o_s_axi_arready,      // read address ready
    output utsc_pkg::data_t       o_s_axi_rdata,        // read data
    output utsc_pkg::resp_t       o_s_axi_rresp,        // read response
    output logic                  o_s_axi_rvalid,       // read data valid
    input  wire logic             i_s_axi_rready,       // read data ready
    input  wire utsc_pkg::pix_t   i_pixel_count,        // output pixel counter
    input  wire utsc_pkg::line_t  i_line_count,         // output line counter
    input  wire logic             i_interlaced,         // interlaced standard
    input  wire utsc_pkg::line_t  i_lines_per_field,    // lines in odd field
    output logic                  o_user_b_horiz_component, // horizontal window
    output logic                  o_user_b_vert_component,  // vertical window
    output logic                  o_user_b_combined_output  // combined pin level
);
    import utsc_pkg::*;

    // ---- register storage ----
    pix_t                 h_start_reg;   // horizontal start pixel
    pix_t                 h_end_reg;     // horizontal end pixel
    line_t                v_start_reg;   // vertical start line
    line_t                v_end_reg;     // vertical end line
    logic [`UTSC_OP_W-1:0] op_reg;       // polarity and operator bits

    // ---- write channel state ----
    wr_state_t            wr_state_reg;  // write sequence state
    logic                 aw_held_reg;   // address captured
    logic                 w_held_reg;    // data captured
    addr_t                aw_addr_reg;   // captured address
    data_t                w_data_reg;    // captured data
    strb_t                w_strb_reg;    // captured byte enables
    resp_t                bresp_reg;     // write answer

    // ---- read channel state ----
    rd_state_t            rd_state_reg;  // read sequence state
    data_t                rdata_reg;     // read word
    resp_t                rresp_reg;     // read answer

    // ---- decode wires ----
    logic                 aw_take;       // address handshake
    logic                 w_take;        // data handshake
    logic                 ar_take;       // read address handshake
    logic                 wr_fire;       // both halves present
    logic [7:0]           wr_index;      // write register index
    logic [7:0]           rd_index;      // read register index
    logic                 wr_aligned;    // write address aligned
    logic                 rd_aligned;    // read address aligned
    logic                 wr_hit_hs;     // write hits h start
    logic                 wr_hit_he;     // write hits h end
    logic                 wr_hit_vs;     // write hits v start
    logic                 wr_hit_ve;     // write hits v end
    logic                 wr_hit_op;     // write hits combine reg
    logic                 wr_hit_st;     // write hits status (read only)
    logic                 wr_mapped;     // write address is known
    logic                 rd_mapped;     // read address is known
    data_t                rd_word;       // read mux result
    data_t                status_word;   // live block state

    // ---- video path wires ----
    line_t                line_folded;   // line in odd-field numbering
    logic                 line_in_even;  // line lies in second field
    logic                 combined_level; // combiner result

    // merge byte lanes 0 and 1 into a 16-bit register image
    function automatic logic [15:0] merge16(
        input logic [15:0] old_val,
        input data_t       data,
        input strb_t       strb
    );
        logic [15:0] res;
        res       = old_val;
        if (strb[0]) begin
            res[7:0] = data[7:0];
        end
        if (strb[1]) begin
            res[15:8] = data[15:8];
        end
        return res;
    endfunction : merge16

    // word index of a byte address
    function automatic logic [7:0] reg_index(input addr_t a);
        return a[9:2];
    endfunction : reg_index

    // low two address bits must be zero
    function automatic logic is_aligned(input addr_t a);
        return a[1:0] == `UTSC_WORD_ALIGN;
    endfunction : is_aligned

    // ---- handshakes ----
    // address and data accepted separately, each once per write
    assign o_s_axi_awready = (wr_state_reg == WR_IDLE) && !aw_held_reg;
    assign o_s_axi_wready  = (wr_state_reg == WR_IDLE) && !w_held_reg;
    assign o_s_axi_bvalid  = (wr_state_reg == WR_RESP);
    assign o_s_axi_bresp   = bresp_reg;
    assign aw_take         = i_s_axi_awvalid && o_s_axi_awready;
    assign w_take          = i_s_axi_wvalid && o_s_axi_wready;
    assign wr_fire         = (wr_state_reg == WR_IDLE) && aw_held_reg && w_held_reg;

    assign o_s_axi_arready = (rd_state_reg == RD_IDLE);
    assign o_s_axi_rvalid  = (rd_state_reg == RD_DATA);
    assign o_s_axi_rdata   = rdata_reg;
    assign o_s_axi_rresp   = rresp_reg;
    assign ar_take         = i_s_axi_arvalid && o_s_axi_arready;

    // ---- write decode ----
    assign wr_index   = reg_index(aw_addr_reg);
    assign wr_aligned = is_aligned(aw_addr_reg);
    assign wr_hit_hs  = wr_aligned && (wr_index == `UTSC_IDX_H_START);
    assign wr_hit_he  = wr_aligned && (wr_index == `UTSC_IDX_H_END);
    assign wr_hit_vs  = wr_aligned && (wr_index == `UTSC_IDX_V_START);
    assign wr_hit_ve  = wr_aligned && (wr_index == `UTSC_IDX_V_END);
    assign wr_hit_op  = wr_aligned && (wr_index == `UTSC_IDX_COMBINE);
    assign wr_hit_st  = wr_aligned && (wr_index == `UTSC_IDX_STATUS);
    assign wr_mapped  = wr_hit_hs | wr_hit_he | wr_hit_vs | wr_hit_ve
                      | wr_hit_op | wr_hit_st;

    // ---- read decode ----
    assign rd_index   = reg_index(i_s_axi_araddr);
    assign rd_aligned = is_aligned(i_s_axi_araddr);

    // live state: components and pin level
    assign status_word = {29'h00000000,
                          o_user_b_combined_output,
                          o_user_b_vert_component,
                          o_user_b_horiz_component};

    // read mux, reserved bits read as zero
    always_comb begin
        rd_word   = 32'h00000000;
        rd_mapped = rd_aligned;
        if (rd_aligned) begin
            unique case (rd_index)
                `UTSC_IDX_H_START: rd_word = {16'h0000, h_start_reg};
                `UTSC_IDX_H_END:   rd_word = {16'h0000, h_end_reg};
                `UTSC_IDX_V_START: rd_word = {17'h00000, v_start_reg};
                `UTSC_IDX_V_END:   rd_word = {17'h00000, v_end_reg};
                `UTSC_IDX_COMBINE: rd_word = {28'h0000000, op_reg};
                `UTSC_IDX_STATUS:  rd_word = status_word;
                default:           rd_mapped = 1'b0;
            endcase
        end
    end

    // capture address half of a write
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            aw_held_reg <= 1'b0;
            aw_addr_reg <= 10'h000;
        end else if (aw_take) begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= i_s_axi_awaddr;
        end else if (o_s_axi_bvalid && i_s_axi_bready) begin
            aw_held_reg <= 1'b0;
        end
    end

    // capture data half of a write
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h00000000;
            w_strb_reg <= 4'h0;
        end else if (w_take) begin
            w_held_reg <= 1'b1;
            w_data_reg <= i_s_axi_wdata;
            w_strb_reg <= i_s_axi_wstrb;
        end else if (o_s_axi_bvalid && i_s_axi_bready) begin
            w_held_reg <= 1'b0;
        end
    end

    // write sequence: commit, then hold response until taken
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_state_reg <= WR_IDLE;
            bresp_reg    <= `UTSC_RESP_OKAY;
        end else begin
            unique case (wr_state_reg)
                WR_IDLE: begin
                    // both halves here: answer next
                    if (wr_fire) begin
                        wr_state_reg <= WR_RESP;
                        bresp_reg    <= wr_mapped ? `UTSC_RESP_OKAY
                                                  : `UTSC_RESP_SLVERR;
                    end
                end
                WR_RESP: begin
                    // master took the answer
                    if (i_s_axi_bready) begin
                        wr_state_reg <= WR_IDLE;
                    end
                end
            endcase
        end
    end

    // horizontal window registers
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            h_start_reg <= `UTSC_H_START_RST;
            h_end_reg   <= `UTSC_H_END_RST;
        end else if (wr_fire) begin
            if (wr_hit_hs) begin
                h_start_reg <= merge16(h_start_reg, w_data_reg, w_strb_reg);
            end
            if (wr_hit_he) begin
                h_end_reg <= merge16(h_end_reg, w_data_reg, w_strb_reg);
            end
        end
    end

    // vertical window registers, bit 15 not stored
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            v_start_reg <= `UTSC_V_START_RST;
            v_end_reg   <= `UTSC_V_END_RST;
        end else if (wr_fire) begin
            if (wr_hit_vs) begin
                v_start_reg <= line_t'(merge16({1'b0, v_start_reg}, w_data_reg,
                                       w_strb_reg));
            end
            if (wr_hit_ve) begin
                v_end_reg <= line_t'(merge16({1'b0, v_end_reg}, w_data_reg,
                                     w_strb_reg));
            end
        end
    end

    // operator and polarity register, bits 15-4 not stored
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            op_reg <= `UTSC_OP_RST;
        end else if (wr_fire && wr_hit_op && w_strb_reg[0]) begin
            op_reg <= w_data_reg[`UTSC_OP_W-1:0];
        end
    end

    // read sequence: one word, held until taken
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rd_state_reg <= RD_IDLE;
            rdata_reg    <= 32'h00000000;
            rresp_reg    <= `UTSC_RESP_OKAY;
        end else begin
            unique case (rd_state_reg)
                RD_IDLE: begin
                    // latch word on address handshake
                    if (ar_take) begin
                        rd_state_reg <= RD_DATA;
                        rdata_reg    <= rd_word;
                        rresp_reg    <= rd_mapped ? `UTSC_RESP_OKAY
                                                  : `UTSC_RESP_SLVERR;
                    end
                end
                RD_DATA: begin
                    // master took the word
                    if (i_s_axi_rready) begin
                        rd_state_reg <= RD_IDLE;
                    end
                end
            endcase
        end
    end

    // ---- video path ----
    // second-field lines folded to odd-field numbers
    assign line_in_even = i_interlaced && (i_line_count > i_lines_per_field);
    assign line_folded  = line_in_even ? line_t'(i_line_count - i_lines_per_field)
                                       : i_line_count;

    window_compare #(
        .W (`UTSC_PIX_W)
    ) u_horiz_window (
        .i_clock  (i_clock),
        .i_rst_n  (i_rst_n),
        .i_count  (i_pixel_count),
        .i_start  (h_start_reg),
        .i_end    (h_end_reg),
        .o_active (o_user_b_horiz_component)
    );

    window_compare #(
        .W (`UTSC_LINE_W)
    ) u_vert_window (
        .i_clock  (i_clock),
        .i_rst_n  (i_rst_n),
        .i_count  (line_folded),
        .i_start  (v_start_reg),
        .i_end    (v_end_reg),
        .o_active (o_user_b_vert_component)
    );

    signal_combiner u_combiner (
        .i_horiz    (o_user_b_horiz_component),
        .i_vert     (o_user_b_vert_component),
        .i_sel_and  (op_reg[`UTSC_OP_AND_BIT]),
        .i_sel_or   (op_reg[`UTSC_OP_OR_BIT]),
        .i_sel_xor  (op_reg[`UTSC_OP_XOR_BIT]),
        .i_polarity (op_reg[`UTSC_OP_POL_BIT]),
        .o_level    (combined_level)
    );

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            // inactive level of the active-low default
            o_user_b_combined_output <= 1'b1;
        end else begin
            o_user_b_combined_output <= combined_level;
        end
    end
endmodule : user_timing_signal_two_combiner

// *** utsc_checker_assertions.sv ***
`timescale 1ns/1ps
// watches bus handshakes and video levels at the block's ports
module utsc_checker (
    input wire logic            i_clock,
    input wire logic            i_rst_n,
    input wire logic            i_s_axi_awvalid,
    input wire logic            o_s_axi_awready,
    input wire logic            i_s_axi_wvalid,
    input wire logic            o_s_axi_wready,
    input wire utsc_pkg::resp_t o_s_axi_bresp,
    input wire logic            o_s_axi_bvalid,
    input wire logic            i_s_axi_bready,
    input wire logic            i_s_axi_arvalid,
    input wire logic            o_s_axi_arready,
    input wire logic            o_s_axi_rvalid,
    input wire logic            i_s_axi_rready,
    input wire utsc_pkg::pix_t  i_pixel_count,
    input wire utsc_pkg::line_t i_line_count,
    input wire logic            i_interlaced,
    input wire utsc_pkg::line_t i_lines_per_field,
    input wire logic            o_user_b_horiz_component,
    input wire logic            o_user_b_vert_component,
    input wire logic            o_user_b_combined_output
);
    import utsc_pkg::*;
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    // horizontal level moves only with the pixel count or a write
    horiz_hold_a: assert property (
        $stable(i_pixel_count) && !o_s_axi_bvalid |=> $stable(o_user_b_horiz_component)
    ) else $error("horizontal level moved without cause");
    // vertical level moves only with line inputs or a write
    vert_hold_a: assert property (
        $stable(i_line_count) && $stable(i_interlaced) && $stable(i_lines_per_field)
        && !o_s_axi_bvalid |=> $stable(o_user_b_vert_component)
    ) else $error("vertical level moved without cause");
    // combined pin follows the components one clock later
    comb_hold_a: assert property (
        $stable(o_user_b_horiz_component) && $stable(o_user_b_vert_component)
        && !o_s_axi_bvalid |=> $stable(o_user_b_combined_output)
    ) else $error("combined level moved without cause");
    // out of reset the pin is high and components idle
    reset_levels_a: assert property ($rose(i_rst_n) |-> o_user_b_combined_output
        && !o_user_b_horiz_component && !o_user_b_vert_component)
        else $error("wrong levels after reset");
    // write answer two clocks after both halves taken
    write_answer_a: assert property (i_s_axi_awvalid && o_s_axi_awready && i_s_axi_wvalid
        && o_s_axi_wready |=> ##1 o_s_axi_bvalid) else $error("write answer late");
    // write answer ends at its handshake
    write_close_a: assert property (o_s_axi_bvalid && i_s_axi_bready |=> !o_s_axi_bvalid)
        else $error("write answer stayed up");
    // read answer one clock after address taken
    read_answer_a: assert property (i_s_axi_arvalid && o_s_axi_arready |=> o_s_axi_rvalid)
        else $error("read answer late");
    // read answer ends at its handshake
    read_close_a: assert property (o_s_axi_rvalid && i_s_axi_rready |=> !o_s_axi_rvalid)
        else $error("read answer stayed up");
    // no new read address while data waits
    read_block_a: assert property (o_s_axi_rvalid |-> !o_s_axi_arready)
        else $error("read address taken while data pending");
    cover property (o_user_b_horiz_component && o_user_b_vert_component);
    cover property (o_s_axi_bvalid && o_s_axi_bresp == 2'h2);
    cover property ($fell(o_user_b_combined_output));
endmodule : utsc_checker
bind user_timing_signal_two_combiner utsc_checker u_chk (
    .i_clock, .i_rst_n, .i_s_axi_awvalid, .o_s_axi_awready, .i_s_axi_wvalid,
    .o_s_axi_wready, .o_s_axi_bresp, .o_s_axi_bvalid, .i_s_axi_bready, .i_s_axi_arvalid,
    .o_s_axi_arready, .o_s_axi_rvalid, .i_s_axi_rready, .i_pixel_count, .i_line_count,
    .i_interlaced, .i_lines_per_field, .o_user_b_horiz_component,
    .o_user_b_vert_component, .o_user_b_combined_output);

// *** utsc_defs.svh ***
`ifndef UTSC_DEFS_SVH
`define UTSC_DEFS_SVH

// register indices, byte address is four times the index
`define UTSC_IDX_H_START   8'h5C
`define UTSC_IDX_H_END     8'h5D
`define UTSC_IDX_V_START   8'h5E
`define UTSC_IDX_V_END     8'h5F
`define UTSC_IDX_COMBINE   8'h60
`define UTSC_IDX_STATUS    8'h70

// combine register field positions
`define UTSC_OP_XOR_BIT    0
`define UTSC_OP_OR_BIT     1
`define UTSC_OP_AND_BIT    2
`define UTSC_OP_POL_BIT    3

// field widths
`define UTSC_OP_W          4
`define UTSC_LINE_W        15
`define UTSC_PIX_W         16

// reset values
`define UTSC_H_START_RST   16'h0000
`define UTSC_H_END_RST     16'h0000
`define UTSC_V_START_RST   15'h0000
`define UTSC_V_END_RST     15'h0000
`define UTSC_OP_RST        4'h8

// status register bit positions
`define UTSC_ST_HORIZ_BIT  0
`define UTSC_ST_VERT_BIT   1
`define UTSC_ST_OUT_BIT    2

// bus answers and word alignment
`define UTSC_RESP_OKAY     2'h0
`define UTSC_RESP_SLVERR   2'h2
`define UTSC_WORD_ALIGN    2'h0

`endif

// *** utsc_pkg.sv ***
package utsc_pkg;
    typedef logic [9:0]  addr_t;  // byte address
    typedef logic [31:0] data_t;  // bus word
    typedef logic [3:0]  strb_t;  // byte enables
    typedef logic [1:0]  resp_t;  // bus response
    typedef logic [15:0] pix_t;   // pixel count
    typedef logic [14:0] line_t;  // line count
    typedef enum logic { WR_IDLE, WR_RESP } wr_state_t;
    typedef enum logic { RD_IDLE, RD_DATA } rd_state_t;
endpackage : utsc_pkg

// *** window_compare.sv ***
`timescale 1ns/1ps
// registered window: active from start count up to end count
module window_compare #(
    parameter int W = 16
) (
    input  wire logic         i_clock,   // video clock
    input  wire logic         i_rst_n,   // async reset, active low
    input  wire logic [W-1:0] i_count,   // current counter value
    input  wire logic [W-1:0] i_start,   // first active count
    input  wire logic [W-1:0] i_end,     // first inactive count
    output logic              o_active   // window level
);
    logic in_window;  // combinational compare

    // active on start, inactive again on end
    assign in_window = (i_count >= i_start) && (i_count < i_end);

    // compare taken every clock
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_active <= 1'b0;
        end else begin
            o_active <= in_window;
        end
    end
endmodule : window_compare
